// >>> logic/slev_line_status.v
// Line event latching and status read-back for one serial channel.
//
// Behaviour
// RQ1: Async mode: alignment pin falling sets alignment flag and raises a line event.
// RQ2: Async mode: alignment pin rising clears alignment flag and raises a line event.
// RQ3: Other events freeze the flag at the inverted pin; reset command shows live level.
// RQ4: External mode: begin-search arms detection; high pin holds flag cleared.
// RQ5: External logic pulls pin low two receive clock rises after last alignment bit.
// RQ6: External logic holds pin low until host reports lost alignment or new message.
// RQ7: External mode: pin returning high raises another line event.
// RQ8: Begin-search again resumes waiting for the pin falling edge.
// RQ9: Character modes: begin-search sets flag; alignment clears it with line event.
// RQ10: Character modes: flag rising after begin-search raises a line event.
// RQ11: Character modes: alignment pin is an output, driven low on pattern found.
// RQ12: SDLC: flag set by begin-search or receiver disable; opening flag clears it.
// RQ13: SDLC: alignment kept after message end; only begin-search or disable sets flag.
// RQ14: Clear-to-send bit latches like carrier bit, showing inverted pin level.
// RQ15: Underrun flag set by any reset, cleared only by underrun reset command.
// RQ16: Transmit underrun sets the flag and raises a pending line event.
// RQ17: Async: null with framing error sets break flag; end seen after reset command.
// RQ18: Break end clears flag with line event; next break needs another reset.
// RQ19: Host should discard one stray null character after a break ends.
// RQ20: SDLC abort sets break flag like break; unused in character modes.
// RQ21: Special receive status layout: frame end, errors, residue code, all-sent.
// RQ22: All-sent tracks transmitter in async, reads one in sync, never interrupts.
// RQ23: Status freezes on a latched event until the line event reset command.
`timescale 1ns/1ps
`include "slev_regs.vh"
`default_nettype none
module slev_line_status (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Host command and read port
  input wire cmd_wr,
  input wire [7:0] cmd_data,
  input wire rd_sel,
  output reg [7:0] rd_data,
  output wire line_event_irq,
  // Configuration
  input wire [2:0] mode,
  input wire line_event_int_en,
  input wire begin_search,
  input wire rx_enable,
  // Line pins
  input wire receive_bit_clock,
  input wire align_pin_i,
  output reg align_pin_o,
  output wire align_pin_oe,
  input wire cts_n,
  input wire dcd_n,
  // Receiver and transmitter events, same clock
  input wire tx_underrun,
  input wire rx_null_framing,
  input wire rx_break_end,
  input wire sdlc_abort,
  input wire sdlc_open_flag,
  input wire char_aligned,
  input wire pattern_found,
  // Other status, same clock
  input wire rx_char_avail,
  input wire int_pending,
  input wire tx_buf_empty,
  input wire tx_all_sent,
  input wire end_of_frame,
  input wire crc_framing_error,
  input wire rx_overrun,
  input wire parity_error,
  input wire [2:0] residue_code
);
  localparam NEV = 5;
  localparam IDX_CARRIER = 0;
  localparam IDX_ALIGN = 1;
  localparam IDX_CTS = 2;
  localparam IDX_UNDERRUN = 3;
  localparam IDX_BREAK = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and receive clock edge.

  wire [3:0] pins_s;
  wire rxc_s;
  wire align_s;
  wire cts_s;
  wire dcd_s;
  reg rxc_prev_q;
  reg align_rx_q;
  wire rxc_rise;

  slev_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({receive_bit_clock, align_pin_i, cts_n, dcd_n}),
    .sync_out(pins_s)
  );

  assign rxc_s = pins_s[3];
  assign align_s = pins_s[2];
  assign cts_s = pins_s[1];
  assign dcd_s = pins_s[0];
  assign rxc_rise = rxc_s & ~rxc_prev_q;

  // External alignment logic changes the pin in step with the receive clock,
  // so the pin is taken on a receive clock rise to match that timing.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rxc_prev_q <= 1'b1;
      align_rx_q <= 1'b1;
    end else begin
      rxc_prev_q <= rxc_s;
      if (mode != `SLEV_MODE_EXT_ALIGN || rxc_rise) begin
        align_rx_q <= align_s; // RQ5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding and internal line conditions.

  function is_char_mode;
    input [2:0] m;
    begin
      is_char_mode = (m == `SLEV_MODE_ONE_CHAR) || (m == `SLEV_MODE_TWO_CHAR);
    end
  endfunction

  wire char_mode = is_char_mode(mode);
  wire async_mode = (mode == `SLEV_MODE_ASYNC);
  wire ext_mode = (mode == `SLEV_MODE_EXT_ALIGN);
  wire sdlc_mode = (mode == `SLEV_MODE_SDLC);
  wire line_reset_cmd = cmd_wr &&
    (cmd_data[`SLEV_CMD_CODE_HI:`SLEV_CMD_CODE_LO] == `SLEV_CMD_LINE_EVENT_RESET_CODE);
  wire underrun_reset_cmd = cmd_wr &&
    (cmd_data[`SLEV_CMD_RESET_HI:`SLEV_CMD_RESET_LO] == `SLEV_CMD_UNDERRUN_RESET);

  reg ext_armed_q;
  reg hunt_q;
  reg hunt_d;
  reg break_q;
  reg break_d;
  reg underrun_q;

  // Begin-search re-arms the external detector after alignment was lost.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ext_armed_q <= 1'b0;
    end else if (!ext_mode) begin
      ext_armed_q <= 1'b0;
    end else if (begin_search) begin
      ext_armed_q <= 1'b1; // RQ4 RQ8
    end
  end

  // Hunt state for the modes where the device aligns by itself.
  always @* begin
    hunt_d = hunt_q;
    if (char_mode) begin
      if (begin_search) begin
        hunt_d = 1'b1; // RQ9 RQ10
      end else if (char_aligned) begin
        hunt_d = 1'b0; // RQ9
      end
    end else if (sdlc_mode) begin
      if (begin_search || !rx_enable) begin
        hunt_d = 1'b1; // RQ12 RQ13
      end else if (sdlc_open_flag) begin
        hunt_d = 1'b0; // RQ12
      end
    end
  end

  // Break and abort state; ending a break depends on the receiver seeing it.
  always @* begin
    break_d = break_q;
    case (mode)
      `SLEV_MODE_ASYNC: begin
        if (rx_null_framing) begin
          break_d = 1'b1; // RQ17
        end else if (rx_break_end) begin
          break_d = 1'b0; // RQ18
        end
      end
      `SLEV_MODE_SDLC: begin
        if (sdlc_abort) begin
          break_d = 1'b1; // RQ20
        end else if (rx_break_end) begin
          break_d = 1'b0; // RQ20
        end
      end
      default: begin
        break_d = 1'b0; // RQ20
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      hunt_q <= 1'b1;
      break_q <= 1'b0;
      underrun_q <= `SLEV_RST_UNDERRUN; // RQ15
    end else begin
      hunt_q <= hunt_d;
      break_q <= break_d;
      // An underrun arriving with the reset command wins.
      if (tx_underrun) begin
        underrun_q <= 1'b1; // RQ16
      end else if (underrun_reset_cmd) begin
        underrun_q <= 1'b0; // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live alignment flag per mode.

  reg align_live;

  always @* begin
    case (mode)
      `SLEV_MODE_ASYNC: align_live = ~align_s; // RQ1 RQ2 RQ3
      `SLEV_MODE_EXT_ALIGN: align_live = ext_armed_q & ~align_rx_q; // RQ4 RQ7
      `SLEV_MODE_ONE_CHAR: align_live = hunt_q;
      `SLEV_MODE_TWO_CHAR: align_live = hunt_q;
      `SLEV_MODE_SDLC: align_live = hunt_q;
      default: align_live = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event latch: shown bits follow the live ones until a change latches them.

  wire [NEV-1:0] live;
  reg [NEV-1:0] live_prev_q;
  reg [NEV-1:0] shown_q;
  reg latched_q;
  wire changed_now;

  assign live[IDX_CARRIER] = ~dcd_s;
  assign live[IDX_ALIGN] = align_live;
  assign live[IDX_CTS] = ~cts_s; // RQ14
  assign live[IDX_UNDERRUN] = underrun_q;
  assign live[IDX_BREAK] = break_q;
  assign changed_now = (live != live_prev_q);

  // A change in the reset cycle keeps the latch set, so no event is lost.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      live_prev_q <= {NEV{1'b0}};
      shown_q <= {NEV{1'b0}};
      latched_q <= 1'b0;
    end else begin
      live_prev_q <= live;
      if (line_reset_cmd) begin
        shown_q <= live; // RQ3 RQ23
        latched_q <= changed_now; // RQ23
      end else if (!latched_q) begin
        shown_q <= live; // RQ1 RQ2
        if (live != shown_q) begin
          latched_q <= 1'b1; // RQ1 RQ2 RQ7 RQ9 RQ10 RQ12 RQ16 RQ17 RQ18
        end
      end
    end
  end

  // The freeze also blocks the next break until the host resets the latch.
  assign line_event_irq = latched_q & line_event_int_en; // RQ1 RQ16 RQ23

  ////////////////////////////////////////////////////////////////////////////
  // Alignment pin driver for the character modes.

  assign align_pin_oe = char_mode; // RQ11

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      align_pin_o <= 1'b1;
    end else begin
      align_pin_o <= ~(char_mode & pattern_found); // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status read-back.

  wire [7:0] srs;
  reg [7:0] lbs;

  slev_srs u_srs (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_mode(async_mode),
    .tx_all_sent(tx_all_sent),
    .end_of_frame(end_of_frame),
    .crc_framing_error(crc_framing_error),
    .rx_overrun(rx_overrun),
    .parity_error(parity_error),
    .residue_code(residue_code),
    .srs_q(srs)
  );

  always @* begin
    lbs = `SLEV_RST_BYTE;
    lbs[`SLEV_LBS_RX_AVAIL] = rx_char_avail;
    lbs[`SLEV_LBS_INT_PEND] = int_pending;
    lbs[`SLEV_LBS_TX_EMPTY] = tx_buf_empty;
    lbs[`SLEV_LBS_CARRIER] = shown_q[IDX_CARRIER];
    lbs[`SLEV_LBS_ALIGN] = shown_q[IDX_ALIGN];
    lbs[`SLEV_LBS_CTS] = shown_q[IDX_CTS]; // RQ14
    lbs[`SLEV_LBS_UNDERRUN] = shown_q[IDX_UNDERRUN];
    lbs[`SLEV_LBS_BREAK] = shown_q[IDX_BREAK];
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_data <= `SLEV_RST_BYTE;
    end else if (rd_sel == `SLEV_PTR_SPECIAL_RECEIVE_STATUS) begin
      rd_data <= srs; // RQ21 RQ22
    end else begin
      rd_data <= lbs;
    end
  end
endmodule // slev_line_status
`default_nettype wire

// >>> logic/slev_regs.vh
// Constants for the serial line event status block.
`ifndef SLEV_REGS_VH
`define SLEV_REGS_VH

// Read pointer values selecting the status registers.
`define SLEV_PTR_LINE_BUFFER_STATUS 1'b0
`define SLEV_PTR_SPECIAL_RECEIVE_STATUS 1'b1

// Channel operating modes.
`define SLEV_MODE_ASYNC 3'h0
`define SLEV_MODE_EXT_ALIGN 3'h1
`define SLEV_MODE_ONE_CHAR 3'h2
`define SLEV_MODE_TWO_CHAR 3'h3
`define SLEV_MODE_SDLC 3'h4

// Command register fields.
`define SLEV_CMD_CODE_HI 5
`define SLEV_CMD_CODE_LO 3
`define SLEV_CMD_RESET_HI 7
`define SLEV_CMD_RESET_LO 6
`define SLEV_CMD_LINE_EVENT_RESET_CODE 3'h2
`define SLEV_CMD_UNDERRUN_RESET 2'h3

// Line buffer status bit positions.
`define SLEV_LBS_RX_AVAIL 0
`define SLEV_LBS_INT_PEND 1
`define SLEV_LBS_TX_EMPTY 2
`define SLEV_LBS_CARRIER 3
`define SLEV_LBS_ALIGN 4
`define SLEV_LBS_CTS 5
`define SLEV_LBS_UNDERRUN 6
`define SLEV_LBS_BREAK 7

// Special receive status bit positions.
`define SLEV_SRS_ALL_SENT 0
`define SLEV_SRS_RESIDUE_LO 1
`define SLEV_SRS_RESIDUE_HI 3
`define SLEV_SRS_PARITY 4
`define SLEV_SRS_OVERRUN 5
`define SLEV_SRS_CRC_FRAMING 6
`define SLEV_SRS_END_OF_FRAME 7

// Reset values.
`define SLEV_RST_UNDERRUN 1'b1
`define SLEV_RST_BYTE 8'h00

`endif

// >>> logic/slev_srs.v
// Special receive status register assembly with the all-sent bit.
`timescale 1ns/1ps
`include "slev_regs.vh"
`default_nettype none
module slev_srs (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Mode and receiver status
  input wire async_mode,
  input wire tx_all_sent,
  input wire end_of_frame,
  input wire crc_framing_error,
  input wire rx_overrun,
  input wire parity_error,
  input wire [2:0] residue_code,
  // Register value
  output reg [7:0] srs_q
);
  reg [7:0] srs_d;

  always @* begin
    srs_d = `SLEV_RST_BYTE;
    srs_d[`SLEV_SRS_END_OF_FRAME] = end_of_frame; // RQ21
    srs_d[`SLEV_SRS_CRC_FRAMING] = crc_framing_error; // RQ21
    srs_d[`SLEV_SRS_OVERRUN] = rx_overrun; // RQ21
    srs_d[`SLEV_SRS_PARITY] = parity_error; // RQ21
    srs_d[`SLEV_SRS_RESIDUE_HI:`SLEV_SRS_RESIDUE_LO] = residue_code; // RQ21
    // Synchronous modes have no notion of a draining transmitter.
    srs_d[`SLEV_SRS_ALL_SENT] = async_mode ? tx_all_sent : 1'b1; // RQ22
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      srs_q <= `SLEV_RST_BYTE;
    end else begin
      srs_q <= srs_d;
    end
  end
endmodule // slev_srs
`default_nettype wire

// >>> logic/slev_sync.v
// Two flip-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module slev_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] stable_q;

  // Reset value is all ones: every synchronised pin idles high.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      meta_q <= {WIDTH{1'b1}};
      stable_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule // slev_sync
`default_nettype wire

// >>> verification/slev_line_model.sv
// Serial line partner with external alignment logic.
`timescale 1ns/1ps
`default_nettype none
module slev_line_model (
  // Host requests
  input wire logic go,
  input wire logic rel,
  // Line pins
  output logic rbc,
  output logic pin
);
  initial begin
    rbc = 1'h0;
    pin = 1'h1;
  end
  // The clock runs only in a frame; rise eight carries the last alignment bit.
  always @(posedge go) begin
    for (int i = 1; i <= 12; i++) begin
      #400 rbc = 1'h1;
      #20;
      if (i == 10)
        pin = 1'h0;
      #380 rbc = 1'h0;
    end
  end
  // Two clocks after release let the device sample the rise.
  always @(posedge rel) begin
    pin = 1'h1;
    repeat (2) begin
      #400 rbc = 1'h1;
      #400 rbc = 1'h0;
    end
  end
endmodule // slev_line_model
`default_nettype wire

// >>> verification/slev_line_status_checker.sv
// Assertions on the line event status block ports.
`timescale 1ns/1ps
`default_nettype none
module slev_line_status_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Host side
  input wire logic cmd_wr,
  input wire logic rd_sel,
  input wire logic [7:0] rd_data,
  input wire logic line_event_irq,
  input wire logic [2:0] mode,
  input wire logic line_event_int_en,
  // Alignment pin
  input wire logic align_pin_o,
  input wire logic align_pin_oe,
  input wire logic pattern_found,
  // Receive status
  input wire logic end_of_frame,
  input wire logic crc_framing_error,
  input wire logic rx_overrun,
  input wire logic parity_error,
  input wire logic [2:0] residue_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic [6:0] err_bits = {end_of_frame, crc_framing_error, rx_overrun, parity_error,
    residue_code};
  sequence sync_sel_s; (rd_sel && mode != 3'h0) [*3]; endsequence
  sequence steady_s; (rd_sel && $stable(err_bits)) [*3]; endsequence
  sequence after_rst_s; $rose(rst_b) ##0 (!rd_sel && !cmd_wr) [*6]; endsequence
  oe_mode_a: assert property (align_pin_oe == (mode == 3'h2 || mode == 3'h3))
    else $error("pin enable wrong");
  pattern_low_a: assert property (align_pin_oe && pattern_found |=> !align_pin_o)
    else $error("pin not low");
  idle_high_a: assert property (!align_pin_oe && $stable(mode) |-> align_pin_o)
    else $error("pin not high");
  irq_gate_a: assert property (line_event_irq |-> line_event_int_en)
    else $error("irq not gated");
  frozen_a: assert property (
    (line_event_irq && !cmd_wr) ##1 line_event_int_en |-> line_event_irq)
    else $error("irq dropped");
  all_sent_a: assert property (sync_sel_s |-> rd_data[0])
    else $error("all sent low");
  layout_a: assert property (steady_s |-> rd_data[7:1] == err_bits)
    else $error("status layout wrong");
  underrun_rst_a: assert property (after_rst_s |-> rd_data[6])
    else $error("underrun not set");
endmodule // slev_line_status_checker
`default_nettype wire

// >>> verification/slev_line_status_tb.sv
// Self-checking bench for the line event status block.
`timescale 1ns/1ps
`default_nettype none
module slev_line_status_tb;
  logic clk_sys = 1'h0;
  logic rst_b, cmd_wr, rd_sel, line_event_int_en, rx_enable, cts_n, dcd_n, tb_pin, go, rel;
  logic [2:0] lb;
  logic [7:0] cmd_data, ev, sr, msk;
  logic [2:0] mode;
  logic [8:0] q[$];
  wire logic [7:0] rd_data;
  wire logic line_event_irq, align_pin_o, align_pin_oe, rbc, mdl_pin;
  wire logic align_w = align_pin_oe ? align_pin_o : (mode == 3'h1 ? mdl_pin : tb_pin);
  int n_errors = 0;
  int samples_checked = 0;
  event seen;
  always #50 clk_sys = ~clk_sys;
  slev_line_model slev_line_model_inst (.go, .rel, .rbc, .pin(mdl_pin));
  slev_line_status slev_line_status_inst (.clk_sys, .rst_b, .cmd_wr, .cmd_data, .rd_sel,
    .rd_data, .line_event_irq, .mode, .line_event_int_en, .begin_search(ev[7]),
    .rx_enable, .receive_bit_clock(rbc), .align_pin_i(align_w), .align_pin_o,
    .align_pin_oe, .cts_n, .dcd_n, .tx_underrun(ev[0]), .rx_null_framing(ev[1]),
    .rx_break_end(ev[2]), .sdlc_abort(ev[3]), .sdlc_open_flag(ev[4]),
    .char_aligned(ev[5]), .pattern_found(ev[6]), .rx_char_avail(lb[0]),
    .int_pending(lb[1]), .tx_buf_empty(lb[2]), .tx_all_sent(sr[0]),
    .end_of_frame(sr[7]), .crc_framing_error(sr[6]), .rx_overrun(sr[5]),
    .parity_error(sr[4]), .residue_code(sr[3:1]));
  task automatic chk(logic [8:0] s, logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(int i);
    ev[i] = 1'h1;
    cyc(1);
    ev = 8'h00;
    cyc(4);
  endtask
  task automatic cmd(logic [7:0] b);
    cmd_data = b;
    cmd_wr = 1'h1;
    cyc(1);
    cmd_wr = 1'h0;
    cyc(2);
  endtask
  task automatic ack;
    cmd(8'h10);
    cyc(2);
  endtask
  // Each read notes its expectation; the monitor compares when the data is shown.
  task automatic rd(logic s, logic [7:0] m, logic i, logic [7:0] e);
    rd_sel = s;
    cyc(3);
    msk = m;
    q.push_back({i, e});
    ->seen;
    // Hold every input until the monitor has taken its sample in this time step.
    cyc(1);
  endtask
  always @(seen) chk({line_event_irq, rd_data & msk}, q.pop_front());
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    wrap_up;
  end
  initial begin
    {rst_b, cmd_wr, rd_sel, go, rel, ev, sr, cmd_data, mode, msk, lb} = '0;
    {line_event_int_en, rx_enable, cts_n, dcd_n, tb_pin} = 5'h1f;
    void'($urandom(32'h7ce5));
    cyc(20);
    rst_b = 1'h1;
    cyc(6);
    rd(1'h0, 8'h40, 1'h1, 8'h40);
    ack;
    rd(1'h0, 8'h40, 1'h0, 8'h40);
    cmd(8'hc0);
    ack;
    rd(1'h0, 8'h40, 1'h0, 8'h00);
    pulse(0);
    rd(1'h0, 8'h40, 1'h1, 8'h40);
    tb_pin = 1'h0;
    cyc(6);
    ack;
    cts_n = 1'h0;
    dcd_n = 1'h0;
    cyc(6);
    tb_pin = 1'h1;
    cyc(6);
    rd(1'h0, 8'h38, 1'h1, 8'h38);
    ack;
    rd(1'h0, 8'h38, 1'h0, 8'h28);
    tb_pin = 1'h0;
    cyc(6);
    rd(1'h0, 8'h10, 1'h1, 8'h10);
    ack;
    tb_pin = 1'h1;
    cyc(6);
    rd(1'h0, 8'h10, 1'h1, 8'h00);
    ack;
    line_event_int_en = 1'h0;
    pulse(1);
    rd(1'h0, 8'h80, 1'h0, 8'h80);
    line_event_int_en = 1'h1;
    rd(1'h0, 8'h80, 1'h1, 8'h80);
    ack;
    pulse(2);
    // A stray null waits in the receiver after the break; the host drains it.
    lb = 3'($urandom);
    rd(1'h0, 8'h87, 1'h1, {5'h00, lb});
    lb = 3'h4;
    ack;
    mode = 3'h1;
    cyc(4);
    ack;
    repeat (2) begin
      pulse(7);
      rd(1'h0, 8'h10, 1'h0, 8'h00);
      go = 1'h1;
      cyc(110);
      go = 1'h0;
      rd(1'h0, 8'h10, 1'h1, 8'h10);
      ack;
      rel = 1'h1;
      cyc(25);
      rel = 1'h0;
      rd(1'h0, 8'h10, 1'h1, 8'h00);
      ack;
    end
    for (int m = 2; m < 4; m++) begin
      mode = 3'(m);
      pulse(5);
      ack;
      pulse(7);
      rd(1'h0, 8'h10, 1'h1, 8'h10);
      ack;
      ev[6] = 1'h1;
      cyc(1);
      ev = 8'h00;
      chk({8'h00, align_pin_o}, 9'h000);
      pulse(5);
      rd(1'h0, 8'h10, 1'h1, 8'h00);
      ack;
    end
    mode = 3'h4;
    cyc(4);
    ack;
    rx_enable = 1'h0;
    cyc(4);
    rd(1'h0, 8'h10, 1'h1, 8'h10);
    rx_enable = 1'h1;
    ack;
    pulse(4);
    rd(1'h0, 8'h90, 1'h1, 8'h00);
    ack;
    pulse(3);
    rd(1'h0, 8'h80, 1'h1, 8'h80);
    ack;
    for (int k = 0; k < 6; k++) begin
      mode = k[0] ? 3'h4 : 3'h0;
      cyc(4);
      ack;
      sr = 8'($urandom);
      rd(1'h1, 8'hff, 1'h0, {sr[7:1], k[0] | sr[0]});
    end
    // A second reset in mid-run must set the cleared underrun flag again.
    cmd(8'hc0);
    ack;
    rd_sel = 1'h0;
    rst_b = 1'h0;
    cyc(2);
    rst_b = 1'h1;
    cyc(6);
    rd(1'h0, 8'h40, 1'h1, 8'h40);
    wrap_up;
  end
endmodule // slev_line_status_tb
bind slev_line_status slev_line_status_checker slev_line_status_checker_inst (.clk_sys,
  .rst_b, .cmd_wr, .rd_sel, .rd_data, .line_event_irq, .mode, .line_event_int_en,
  .align_pin_o, .align_pin_oe, .pattern_found, .end_of_frame, .crc_framing_error,
  .rx_overrun, .parity_error, .residue_code);
`default_nettype wire
